//--- src/sebl_boot_loader.sv
// Boot loader top: fetches commands and data words from a serial EEPROM and
// dispatches them to filter registers and coefficient and pattern stores.
// Assumes boot_select is steady around reset release and the EEPROM reads MSB first.
// Stores carry no reset; their read data is unknown until a command fills them.
// A reset in mid-boot restarts parsing from the first command on release.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Boot select high after reset starts EEPROM read transactions.
// - Select output low through each read, high otherwise.
// - Serial clock near 1.11 MHz, the system clock divided by 18.
// - Output data changes on falling clock edges.
// - EEPROM shifts on falling edges; bits sampled on rising edges.
// - Each read sends opcode 0x03 then a 16-bit address, MSB first.
// - Serial clock and data outputs released when no read is active.
// - Parsing starts at address 0x10; header bytes are never read.
// - Read one command byte, then its 3-byte words, then next command.
// - Continue until the start command, then stop EEPROM activity.
// - Commands are 8 bits; words are 24 bits, MSB byte first.
// - Command 0x01 takes address and value, writes a filter register.
// - Command 0x02 takes two lengths, then first and second stage taps.
// - Each FIR stage holds at most 255 coefficients.
// - Command 0x03 takes eight IIR words in fixed order.
// - Command 0x04 takes one word selecting on-chip coefficient sets.
// - Command 0x05 takes a count, then that many pattern words.
// - Command 0x06 selects the built-in pattern set.
// - Command 0x07 starts the filter and ends boot.
module sebl_boot_loader
	import sebl_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        boot_select,
	output logic             prom_select_n,
	output logic             primary_serial_clock,
	output logic             primary_serial_clock_oe,
	output logic             prom_mosi,
	output logic             prom_mosi_oe,
	input  wire logic        prom_miso,
	output logic             filt_reg_wr,
	output logic [23:0]      filt_reg_addr,
	output logic [23:0]      filt_reg_data,
	output logic             coef_sel_wr,
	output logic [23:0]      coef_sel,
	output logic             tbs_rom_sel,
	output logic             filter_start,
	output logic             boot_busy,
	output logic [7:0]       first_fir_len,
	output logic [7:0]       second_fir_len,
	output logic [10:0]      tbs_len,
	input  wire logic [1:0]  rd_bank,
	input  wire logic [9:0]  rd_addr,
	output logic [23:0]      rd_data
);

	// Loader state: sequencing, running address, counts and output holds
	typedef struct packed {
		sebl_state_e st;
		logic [15:0] addr;
		logic [7:0]  cmd;
		logic [10:0] idx;
		logic [7:0]  n1;
		logic [7:0]  n2;
		logic [10:0] ntbs;
		logic [1:0]  nb;
		logic        start;
		logic        reg_wr;
		logic [23:0] reg_addr;
		logic [23:0] reg_data;
		logic        sel_wr;
		logic [23:0] sel;
		logic        rom_tbs;
		logic        fstart;
		logic        busy;
		logic [23:0] rdo;
	} sebl_top_s;

	// Registered state and its next value
	sebl_top_s q_ff;
	sebl_top_s nxt_q;

	// Coefficient and pattern stores
	logic [23:0] first_fir_stage  [0:254];
	logic [23:0] second_fir_stage [0:254];
	logic [23:0] iir_coef         [0:7];
	logic [23:0] test_pattern_stream [0:1023];

	// Engine handshake and returned bytes
	logic        eng_done;
	logic [23:0] eng_data;

	// Data word bookkeeping for the current command
	logic        word_in;
	logic [10:0] widx;
	logic [10:0] total;
	logic [10:0] second_fir_stage_idx;
	logic [10:0] clip;

	// Store write enables
	logic        we_first_fir_stage;
	logic        we_second_fir_stage;
	logic        we_iir;
	logic        we_tbs;

	// Serial read engine
	sebl_spi_read u_eng (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.start    (q_ff.start),
		.nbytes   (q_ff.nb),
		.addr     (q_ff.addr),
		.miso     (prom_miso),
		.done     (eng_done),
		.rdata    (eng_data),
		.select_n (prom_select_n),
		.sck      (primary_serial_clock),
		.sck_oe   (primary_serial_clock_oe),
		.mosi     (prom_mosi),
		.mosi_oe  (prom_mosi_oe)
	);

	// Words each command consumes, from the counts already captured
	always_comb begin
		unique case (q_ff.cmd)
			CMD_WR_REG:  total = REG_WORDS;
			CMD_WR_FIR:  total = 11'h002 + {3'h0, q_ff.n1} + {3'h0, q_ff.n2};
			CMD_WR_IIR:  total = IIR_WORDS;
			CMD_ROM_COF: total = SEL_WORDS;
			CMD_WR_TBS:  total = 11'h001 + q_ff.ntbs;
			default:     total = 11'h000;
		endcase
	end

	// Store write decode for an arriving data word
	// FIR words 0 and 1 are lengths; later words split at the first length
	assign word_in  = (q_ff.st == ST_WORD_WAIT) && eng_done;
	assign widx     = q_ff.idx - 11'h002;
	assign second_fir_stage_idx = widx - {3'h0, q_ff.n1};
	assign we_first_fir_stage  = word_in && (q_ff.cmd == CMD_WR_FIR) && (q_ff.idx >= 11'h002)
		&& (widx < {3'h0, q_ff.n1});
	assign we_second_fir_stage  = word_in && (q_ff.cmd == CMD_WR_FIR) && (q_ff.idx >= 11'h002)
		&& (widx >= {3'h0, q_ff.n1});
	assign we_iir   = word_in && (q_ff.cmd == CMD_WR_IIR);
	assign we_tbs   = word_in && (q_ff.cmd == CMD_WR_TBS) && (q_ff.idx != 11'h000);

	// Incoming count word saturated to an 11-bit field
	// Surplus words beyond a capped count stay unread, so an over-long
	// image throws the parser out of step; images must keep to the limits
	assign clip = (eng_data[23:11] != 13'h0000) ? 11'h7ff : eng_data[10:0];

	// Loader sequencing
	always_comb begin
		nxt_q = q_ff;
		nxt_q.start  = 1'b0;
		nxt_q.reg_wr = 1'b0;
		nxt_q.sel_wr = 1'b0;
		nxt_q.fstart = 1'b0;
		// Registered store read port, one cycle of latency
		unique case (rd_bank)
			BANK_FIRST_FIR_STAGE: nxt_q.rdo = first_fir_stage[rd_addr[7:0]];
			BANK_SECOND_FIR_STAGE: nxt_q.rdo = second_fir_stage[rd_addr[7:0]];
			BANK_IIR:  nxt_q.rdo = iir_coef[rd_addr[2:0]];
			BANK_TBS:  nxt_q.rdo = test_pattern_stream[rd_addr];
		endcase
		unique case (q_ff.st)
			ST_STRAP: begin
				// Strap sampled one edge after reset release
				nxt_q.st   = boot_select ? ST_CMD_REQ : ST_OFF;
				nxt_q.busy = boot_select;
			end
			ST_CMD_REQ: begin
				// Command byte is a one-byte read
				nxt_q.start = 1'b1;
				nxt_q.nb    = 2'h1;
				nxt_q.st    = ST_CMD_WAIT;
			end
			ST_CMD_WAIT: begin
				if (eng_done) begin
					nxt_q.addr = q_ff.addr + 16'h0001;
					nxt_q.cmd  = eng_data[7:0];
					// Counts belong to the command just fetched
					nxt_q.idx  = 11'h000;
					nxt_q.n1   = 8'h00;
					nxt_q.n2   = 8'h00;
					nxt_q.ntbs = 11'h000;
					if (eng_data[7:0] == CMD_ROM_TBS) begin
						nxt_q.rom_tbs = 1'b1;
					end
					// Start ends the boot; the engine has already released the pins
					if (eng_data[7:0] == CMD_START) begin
						nxt_q.fstart = 1'b1;
						nxt_q.busy   = 1'b0;
						nxt_q.st     = ST_DONE;
					end else begin
						nxt_q.st = ST_NEXT;
					end
				end
			end
			ST_NEXT: begin
				// More words for this command, or on to the next command byte
				nxt_q.st = (q_ff.idx < total) ? ST_WORD_REQ : ST_CMD_REQ;
			end
			ST_WORD_REQ: begin
				// Data word is a three-byte read
				nxt_q.start = 1'b1;
				nxt_q.nb    = 2'h3;
				nxt_q.st    = ST_WORD_WAIT;
			end
			ST_WORD_WAIT: begin
				if (eng_done) begin
					// Step past the three bytes just read
					nxt_q.addr = q_ff.addr + 16'h0003;
					nxt_q.idx  = q_ff.idx + 11'h001;
					nxt_q.st   = ST_NEXT;
					unique case (q_ff.cmd)
						CMD_WR_REG: begin
							if (q_ff.idx == 11'h000) begin
								nxt_q.reg_addr = eng_data;
							end else begin
								nxt_q.reg_data = eng_data;
								nxt_q.reg_wr   = 1'b1;
							end
						end
						CMD_WR_FIR: begin
							// Lengths beyond the store size are capped
							if (q_ff.idx == 11'h000) begin
								nxt_q.n1 = (clip > FIR_MAX) ? 8'hff : clip[7:0];
							end else if (q_ff.idx == 11'h001) begin
								nxt_q.n2 = (clip > FIR_MAX) ? 8'hff : clip[7:0];
							end
						end
						CMD_ROM_COF: begin
							nxt_q.sel    = eng_data;
							nxt_q.sel_wr = 1'b1;
						end
						CMD_WR_TBS: begin
							if (q_ff.idx == 11'h000) begin
								nxt_q.ntbs = (clip > TBS_MAX) ? TBS_MAX : clip;
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_DONE: begin
				// Boot finished: pins stay released until the next reset
				nxt_q.st = ST_DONE;
			end
			ST_OFF: begin
				// Host boot: the loader never touches the serial pins
				nxt_q.st = ST_OFF;
			end
		endcase
	end

	// State register; parsing begins past the header bytes
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q_ff <= '{st: ST_STRAP, addr: CFG_START_ADDR, default: '0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	// Store writes for coefficient and pattern words
	// The first pattern word has word index 1, so its index wraps to slot 0;
	// the count caps keep every index inside its store
	always_ff @(posedge sys_clk) begin
		if (we_first_fir_stage) begin
			first_fir_stage[widx[7:0]] <= eng_data;
		end
		if (we_second_fir_stage) begin
			second_fir_stage[second_fir_stage_idx[7:0]] <= eng_data;
		end
		if (we_iir) begin
			iir_coef[q_ff.idx[2:0]] <= eng_data;
		end
		if (we_tbs) begin
			test_pattern_stream[widx[9:0] + 10'h001] <= eng_data;
		end
	end

	// Filter register, coefficient and pattern select outputs
	assign filt_reg_wr    = q_ff.reg_wr;
	assign filt_reg_addr  = q_ff.reg_addr;
	assign filt_reg_data  = q_ff.reg_data;
	assign coef_sel_wr    = q_ff.sel_wr;
	assign coef_sel       = q_ff.sel;
	assign tbs_rom_sel    = q_ff.rom_tbs;

	// Boot status and counts of the current command
	assign filter_start   = q_ff.fstart;
	assign boot_busy      = q_ff.busy;
	assign first_fir_len  = q_ff.n1;
	assign second_fir_len = q_ff.n2;
	assign tbs_len        = q_ff.ntbs;

	// Store read data
	assign rd_data        = q_ff.rdo;

endmodule
`default_nettype wire

//--- src/sebl_pkg.sv
// Constants, timing counts and state codes for the serial EEPROM boot loader.
// Assumes a 20 MHz system clock; shared by the loader and its serial engine.
package sebl_pkg;

	// Clock rates in kHz and the serial clock half period in system cycles
	localparam int SYS_CLK_KHZ  = 20000;
	localparam int SCK_NOM_KHZ  = 1024;
	localparam int SCK_HALF_RAW = SYS_CLK_KHZ / (2 * SCK_NOM_KHZ);
	localparam int SCK_HALF_CYC = (SCK_HALF_RAW < 1) ? 1 : SCK_HALF_RAW;

	// Serial read framing
	localparam logic [7:0]  PROM_READ_OP   = 8'h03;
	localparam logic [5:0]  HDR_BITS       = 6'h18;
	localparam logic [15:0] CFG_START_ADDR = 16'h0010;

	// Configuration command codes
	localparam logic [7:0] CMD_WR_REG  = 8'h01;
	localparam logic [7:0] CMD_WR_FIR  = 8'h02;
	localparam logic [7:0] CMD_WR_IIR  = 8'h03;
	localparam logic [7:0] CMD_ROM_COF = 8'h04;
	localparam logic [7:0] CMD_WR_TBS  = 8'h05;
	localparam logic [7:0] CMD_ROM_TBS = 8'h06;
	localparam logic [7:0] CMD_START   = 8'h07;

	// Store sizes and fixed word counts
	localparam logic [10:0] FIR_MAX   = 11'h0ff;
	localparam logic [10:0] TBS_MAX   = 11'h400;
	localparam logic [10:0] IIR_WORDS = 11'h008;
	localparam logic [10:0] REG_WORDS = 11'h002;
	localparam logic [10:0] SEL_WORDS = 11'h001;

	// Read bank select for the store read port
	localparam logic [1:0] BANK_FIRST_FIR_STAGE = 2'h0;
	localparam logic [1:0] BANK_SECOND_FIR_STAGE = 2'h1;
	localparam logic [1:0] BANK_IIR  = 2'h2;
	localparam logic [1:0] BANK_TBS  = 2'h3;

	// Loader sequencing states
	typedef enum logic [2:0] {
		ST_STRAP,
		ST_CMD_REQ,
		ST_CMD_WAIT,
		ST_NEXT,
		ST_WORD_REQ,
		ST_WORD_WAIT,
		ST_DONE,
		ST_OFF
	} sebl_state_e;

endpackage

//--- src/sebl_spi_read.sv
// Serial read engine: one select-framed read of opcode, address, 1 to 3 bytes.
// Assumes the EEPROM shifts out on falling edges; pins are released when idle.
`timescale 1ns/1ps
`default_nettype none
module sebl_spi_read
	import sebl_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        start,
	input  wire logic [1:0]  nbytes,
	input  wire logic [15:0] addr,
	input  wire logic        miso,
	output logic             done,
	output logic [23:0]      rdata,
	output logic             select_n,
	output logic             sck,
	output logic             sck_oe,
	output logic             mosi,
	output logic             mosi_oe
);

	typedef struct packed {
		logic        busy;
		logic [4:0]  div;
		logic [5:0]  left;
		logic [47:0] tx;
		logic [23:0] rx;
		logic        sck;
		logic        sel_n;
		logic        oe;
		logic        done;
	} sebl_eng_s;

	localparam logic [4:0] HALF_LAST = 5'(SCK_HALF_CYC - 1);

	sebl_eng_s q_ff;
	sebl_eng_s nxt_q;

	// Frame sequencing and bit shifting
	always_comb begin
		nxt_q = q_ff;
		nxt_q.done = 1'b0;
		if (!q_ff.busy) begin
			if (start) begin
				nxt_q.busy  = 1'b1;
				nxt_q.sel_n = 1'b0;
				nxt_q.oe    = 1'b1;
				nxt_q.sck   = 1'b0;
				nxt_q.div   = 5'h00;
				nxt_q.tx    = {PROM_READ_OP, addr, 24'h000000};
				nxt_q.left  = HDR_BITS + {1'b0, nbytes, 3'h0};
				nxt_q.rx    = 24'h000000;
			end
		end else if (q_ff.div == HALF_LAST) begin
			nxt_q.div = 5'h00;
			if (!q_ff.sck) begin
				// Rising edge: capture the incoming bit
				nxt_q.sck  = 1'b1;
				nxt_q.rx   = {q_ff.rx[22:0], miso};
				nxt_q.left = q_ff.left - 6'h01;
			end else begin
				// Falling edge: advance output or close the frame
				nxt_q.sck = 1'b0;
				if (q_ff.left == 6'h00) begin
					nxt_q.busy  = 1'b0;
					nxt_q.sel_n = 1'b1;
					nxt_q.oe    = 1'b0;
					nxt_q.done  = 1'b1;
				end else begin
					nxt_q.tx = {q_ff.tx[46:0], 1'b0};
				end
			end
		end else begin
			nxt_q.div = q_ff.div + 5'h01;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q_ff <= '{sel_n: 1'b1, default: '0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign done     = q_ff.done;
	assign rdata    = q_ff.rx;
	assign select_n = q_ff.sel_n;
	assign sck      = q_ff.sck;
	assign sck_oe   = q_ff.oe;
	assign mosi     = q_ff.tx[47];
	assign mosi_oe  = q_ff.oe;

endmodule
`default_nettype wire

//--- verif/sebl_boot_loader_bench.sv
// Self-checking bench: the loader boots from a behavioural EEPROM image.
// Assumes the image starts at 0x10 and ends with the start command.
`timescale 1ns/1ps
`default_nettype none
module sebl_boot_loader_bench;
	localparam logic [519:0] IMG = {56'h01000020123456, 128'h02000002000001aa0001aa0002bb0001,
		200'h03c00000c00001c00002c00003c00004c00005c00006c00007,
		112'h0400220005000002d00001d00002, 24'h090607};
	localparam logic [15:0] CA [0:7] = '{16'h10, 16'h17, 16'h27, 16'h40, 16'h44, 16'h4e, 16'h4f, 16'h50};
	localparam int          CW [0:7] = '{2, 5, 8, 1, 3, 0, 0, 0};
	// Store rows: bank, index, expected word
	localparam logic [35:0] ROWS [0:6] = '{{2'h0, 10'h000, 24'haa0001}, {2'h0, 10'h001, 24'haa0002},
		{2'h1, 10'h000, 24'hbb0001}, {2'h2, 10'h000, 24'hc00000}, {2'h2, 10'h007, 24'hc00007},
		{2'h3, 10'h000, 24'hd00001}, {2'h3, 10'h001, 24'hd00002}};
	logic        sys_clk;
	logic        resetn;
	logic        boot_select;
	logic        sel_n;
	logic        sck;
	logic        sck_oe;
	logic        mosi;
	logic        mosi_oe;
	logic [7:0]  f1len;
	logic [7:0]  f2len;
	logic [10:0] tlen;
	logic        miso;
	logic        reg_wr;
	logic [23:0] reg_addr;
	logic [23:0] reg_data;
	logic        csel_wr;
	logic [23:0] csel;
	logic        rom_sel;
	logic        fstart;
	logic        busy;
	logic [1:0]  rd_bank;
	logic [9:0]  rd_addr;
	logic [23:0] rd_data;
	logic [47:0] rw_q [$];
	logic [23:0] cs_q [$];
	int          starts = 0;
	int          n1_pk = 0;
	int          n2_pk = 0;
	int          nt_pk = 0;
	int          bad_count = 0;
	int          check_count = 0;
	int          k;
	int          n;

	sebl_boot_loader dut_u (.sys_clk(sys_clk), .resetn(resetn), .boot_select(boot_select),
		.prom_select_n(sel_n), .primary_serial_clock(sck), .primary_serial_clock_oe(sck_oe),
		.prom_mosi(mosi), .prom_mosi_oe(mosi_oe), .prom_miso(miso), .filt_reg_wr(reg_wr),
		.filt_reg_addr(reg_addr), .filt_reg_data(reg_data), .coef_sel_wr(csel_wr),
		.coef_sel(csel), .tbs_rom_sel(rom_sel), .filter_start(fstart), .boot_busy(busy),
		.first_fir_len(f1len), .second_fir_len(f2len), .tbs_len(tlen), .rd_bank(rd_bank),
		.rd_addr(rd_addr), .rd_data(rd_data));
	sebl_prom_model prom_u (.sel_n(sel_n), .sck(sck), .mosi(mosi), .miso(miso));

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Log loader pulses and peak command counts mid-cycle, where they are settled
	always @(negedge sys_clk) begin
		if (reg_wr === 1'b1) rw_q.push_back({reg_addr, reg_data});
		if (csel_wr === 1'b1) cs_q.push_back(csel);
		if (fstart === 1'b1) starts++;
		if (f1len > n1_pk) n1_pk = int'(f1len);
		if (f2len > n2_pk) n2_pk = int'(f2len);
		if (tlen > nt_pk) nt_pk = int'(tlen);
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (bad_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		resetn = 1'b0;
		boot_select = 1'b1;
		rd_bank = 2'h0;
		rd_addr = 10'h000;
		for (k = 0; k < 8192; k++) prom_u.mem[k] = 8'h07;
		for (k = 0; k < 65; k++) prom_u.mem[16 + k] = IMG[519 - 8 * k -: 8];
		repeat (16) @(negedge sys_clk);
		resetn = 1'b1;
		for (n = 0; n < 60000 && starts == 0; n++) @(negedge sys_clk);
		if (starts == 0) begin
			bad_count++;
			$display("[ERR] %0t start command not seen", $time);
		end else begin
			repeat (2000) @(negedge sys_clk);
			// Reads in order: command byte, then each word at the next address
			k = 0;
			foreach (CA[j]) begin
				for (n = 0; n <= CW[j]; n++) begin
					chk(prom_u.adrs[k], CA[j] + 16'(n ? 3 * n - 2 : 0));
					chk(prom_u.ops[k], 8'h03);
					k++;
				end
			end
			chk(24'(prom_u.adrs.size()), 24'h00001b);
			chk(24'(rw_q.size()), 24'h000001);
			chk(rw_q[0][47:24], 24'h000020);
			chk(rw_q[0][23:0], 24'h123456);
			chk(cs_q[0], 24'h002200);
			chk({23'h0, rom_sel}, 24'h000001);
			chk(24'(starts), 24'h000001);
			chk(24'(n1_pk), 24'h000002);
			chk(24'(n2_pk), 24'h000001);
			chk(24'(nt_pk), 24'h000002);
			// Store contents through the read port
			foreach (ROWS[r]) begin
				rd_bank = ROWS[r][35:34];
				rd_addr = ROWS[r][33:24];
				repeat (2) @(negedge sys_clk);
				chk(rd_data, ROWS[r][23:0]);
			end
			// Strap low: no boot traffic, pins stay released
			resetn = 1'b0;
			boot_select = 1'b0;
			repeat (16) @(negedge sys_clk);
			resetn = 1'b1;
			k = 0;
			repeat (400) begin
				@(negedge sys_clk);
				if (sel_n !== 1'b1 || busy !== 1'b0 || sck_oe !== 1'b0 || mosi_oe !== 1'b0) k++;
			end
			chk(24'(k), 24'h000000);
			// Reset in mid-frame returns select high
			boot_select = 1'b1;
			resetn = 1'b0;
			repeat (16) @(negedge sys_clk);
			resetn = 1'b1;
			repeat (100) @(negedge sys_clk);
			chk({23'h0, sel_n}, 24'h000000);
			chk({22'h0, sck_oe, mosi_oe}, 24'h000003);
			resetn = 1'b0;
			repeat (2) @(negedge sys_clk);
			chk({23'h0, sel_n}, 24'h000001);
		end
		test_done();
	end
endmodule
`default_nettype wire

//--- verif/sebl_boot_loader_checker.sv
// Pin checker for the boot loader: framing, clock timing and pulses.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sebl_boot_loader_checker (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic boot_select,
	input wire logic prom_select_n,
	input wire logic primary_serial_clock,
	input wire logic primary_serial_clock_oe,
	input wire logic prom_mosi,
	input wire logic prom_mosi_oe,
	input wire logic filt_reg_wr,
	input wire logic filter_start,
	input wire logic boot_busy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// Boot start, framing and release of the serial pins
	a_boot_starts_read: assert property ($rose(resetn) && boot_select |-> ##[1:6] !prom_select_n)
		else $error("no read after boot strap");
	a_idle_pins_free: assert property (prom_select_n |-> !primary_serial_clock_oe && !prom_mosi_oe)
		else $error("serial pins driven outside a read");
	a_frame_drives: assert property (!prom_select_n |-> primary_serial_clock_oe && prom_mosi_oe)
		else $error("select low without driven pins");
	a_clock_high_time: assert property ($rose(primary_serial_clock) |->
		primary_serial_clock[*8] ##1 primary_serial_clock ##1 !primary_serial_clock)
		else $error("serial clock high phase wrong");
	a_mosi_on_fall: assert property (!prom_select_n && !$past(prom_select_n) && $changed(prom_mosi)
		|-> $fell(primary_serial_clock))
		else $error("data out changed off a falling edge");
	a_frame_opens: assert property ($fell(prom_select_n) |->
		!prom_mosi && !primary_serial_clock ##9 primary_serial_clock)
		else $error("read frame opened wrongly");
	a_idle_when_free: assert property (!boot_busy |-> prom_select_n)
		else $error("read while not booting");
	a_start_ends_boot: assert property (filter_start |=> !filter_start ##1 !boot_busy)
		else $error("start pulse did not end boot");
	a_reg_pulse: assert property (filt_reg_wr |-> boot_busy ##1 !filt_reg_wr)
		else $error("register write pulse wrong");
endmodule

bind sebl_boot_loader sebl_boot_loader_checker chk_u (
	.sys_clk(sys_clk), .resetn(resetn), .boot_select(boot_select),
	.prom_select_n(prom_select_n), .primary_serial_clock(primary_serial_clock),
	.primary_serial_clock_oe(primary_serial_clock_oe), .prom_mosi(prom_mosi),
	.prom_mosi_oe(prom_mosi_oe), .filt_reg_wr(filt_reg_wr),
	.filter_start(filter_start), .boot_busy(boot_busy)
);
`default_nettype wire

//--- verif/sebl_prom_model.sv
// Behavioural serial EEPROM: mode 0 read, 16-bit address, 8 KB array.
// Assumes select framing by the loader; logs each read's opcode and address.
`timescale 1ns/1ps
`default_nettype none
module sebl_prom_model (
	input  wire logic sel_n,
	input  wire logic sck,
	input  wire logic mosi,
	output var logic  miso
);
	logic [7:0]  mem [0:8191];
	logic [7:0]  ops [$];
	logic [15:0] adrs [$];
	logic [23:0] sh;
	int          cnt;
	int          dcnt;

	initial miso = 1'b0;
	// New frame clears the bit counts
	always @(negedge sel_n) begin
		cnt = 0;
		dcnt = 0;
	end
	// Opcode and address shift in on rising edges
	always @(posedge sck) begin
		if (!sel_n && cnt < 24) begin
			sh = {sh[22:0], mosi};
			cnt = cnt + 1;
			if (cnt == 24) begin
				ops.push_back(sh[23:16]);
				adrs.push_back(sh[15:0]);
			end
		end
	end
	// Data shifts out MSB first on falling edges; junk otherwise
	always @(negedge sck) begin
		if (!sel_n && cnt == 24) begin
			miso <= mem[(sh[15:0] + dcnt / 8) % 8192][7 - dcnt % 8];
			dcnt = dcnt + 1;
		end else begin
			miso <= ~miso;
		end
	end
	// Released line shows no stale value
	always @(posedge sel_n) miso <= ~miso;
endmodule
`default_nettype wire
